// ===== csb_defs.svh
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH
// Address field holding the bank designator
`define CSB_BANK_LSB 12
`define CSB_BANK_MSB 14
// Storage cycle timing points in ns, and cycle length
`define CSB_T_READ_NS 475
`define CSB_T_WLOAD_NS 600
`define CSB_T_INH_NS 675
`define CSB_T_CYCLE_NS 1000
`define CSB_CLK_NS 4
// Register reset values
`define CSB_WORD_RST 18'h00000
`define CSB_BANKS_RST 8'hFF
`define CSB_CNT_RST 9'h000
`define CSB_PAR_RST 3'h7
// First bank of the upper group of four, and banks that are always fitted
`define CSB_HI_BANK 4
`define CSB_FIXED_BANKS 2
`endif

// ===== csb_pkg.sv
package csb_pkg;
   typedef enum logic [1:0] {
      CSB_IDLE = 2'b00,
      CSB_READ = 2'b01,
      CSB_WRITE = 2'b10
   } csb_state_type;
endpackage

// ===== csb_core_store_bank_data_path.sv
// How it works
// - Bank designator is address bits 12 to 14, naming one of eight banks.
// - Read and write drive reach only the chosen bank.
// - An absent designated bank is replaced by a fitted one, fixed mapping.
// - Maps: one bank 00000000, two 01010101, three 01220122, four 01230123.
// - Maps: five 01234444, six 01234545, seven 01234566, eight 01234567.
// - Per-bank select outputs are active low; one blocks that bank.
// - Eighteen-bit data register holds every word for reads and writes.
// - At 475 ns the read strobe loads selected bank sense outputs.
// - Sense gating of banks 2 to 7 needs their presence input.
// - A one-to-zero core switch shows as sense one, captured by strobe.
// - Channel write loads receiver data into register at 600 ns.
// - Processor write loads processor data at 600 ns instead.
// - Zero register bits drive inhibit for their planes later in write.
// - Inhibit enable at 675 ns gates zero bits to fitted banks' inhibit.
// - Two identical parity generators cover low and high nine stages.
// - Each generator forms three three-stage odd groups, then combines them.
// - Odd count drives one output zero; even count leaves all ones.
// - Read reference writes the captured word back to the same address.
// - Read word is passed to the processor data register at the read strobe.
`timescale 1ns/1ps
`include "csb_defs.svh"
module csb_core_store_bank_data_path #(
   parameter int WORD_W = 18,
   parameter int ADDR_W = 15,
   parameter int BANKS = 8
) (
   input wire logic REF_CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic REQ_IN,
   input wire logic WRITE_IN,
   input wire logic CHANNEL_IN,
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic [BANKS-1:0] BANK_FITTED_IN,
   input wire logic [BANKS*WORD_W-1:0] SENSE_IN,
   input wire logic [WORD_W-1:0] RECV_DATA_IN,
   input wire logic [WORD_W-1:0] PROC_DATA_IN,
   output logic BUSY_OUT,
   output logic [BANKS-1:0] BANK_SEL_N_OUT,
   output logic [BANKS-1:0] READ_DRIVE_OUT,
   output logic [BANKS-1:0] WRITE_DRIVE_OUT,
   output logic [BANKS*WORD_W-1:0] INHIBIT_OUT,
   output logic [WORD_W-1:0] DATA_OUT,
   output logic DATA_VALID_OUT,
   output logic [2:0] PARITY_LO_N_OUT,
   output logic [2:0] PARITY_HI_N_OUT
);
   localparam int T_READ = (`CSB_T_READ_NS + `CSB_CLK_NS - 1) / `CSB_CLK_NS;
   localparam int T_WLOAD = (`CSB_T_WLOAD_NS + `CSB_CLK_NS - 1) / `CSB_CLK_NS;
   localparam int T_INH = (`CSB_T_INH_NS + `CSB_CLK_NS - 1) / `CSB_CLK_NS;
   localparam int T_END = `CSB_T_CYCLE_NS / `CSB_CLK_NS;
   localparam int HALF = WORD_W / 2;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Wrap-around bank map: banks fill in groups of four, and a designator that
   // names an absent bank folds back inside its own group; the upper group is
   // only used once its first bank is fitted, otherwise the lower group wraps
   function automatic logic [2:0] map_bank(input logic [2:0] desig, input logic [7:0] fit);
      logic hi;
      logic [1:0] x;
      logic [3:0] grp;
      hi = desig[2] & fit[`CSB_HI_BANK];
      grp = hi ? fit[7:4] : fit[3:0];
      x = desig[1:0];
      if (!grp[x]) x = (x == 2'h3 && grp[2]) ? 2'h2 : {1'b0, x[0]};
      if (!grp[x]) x = 2'h0;
      return {hi, x};
   endfunction

   // Nine-stage parity: three group flags, then four odd combinations, low active
   function automatic logic [2:0] parity9(input logic [8:0] w);
      logic g0, g1, g2;
      logic [2:0] o;
      g0 = ^w[2:0];
      g1 = ^w[5:3];
      g2 = ^w[8:6];
      o = `CSB_PAR_RST;
      if (g0 & ~g1 & ~g2) o[0] = 1'b0;
      if (~g0 & g1 & ~g2) o[1] = 1'b0;
      if ((~g0 & ~g1 & g2) | (g0 & g1 & g2)) o[2] = 1'b0;
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: three stages, change taken when stages two and three agree; write and channel kind are read straight from stage three

   logic [2:0] req_s1_r, req_s2_r, req_s3_r;
   logic req_q_r;
   logic [BANKS-1:0] fit_s1_r, fit_s2_r, fit_s3_r, fit_q_r;
   logic [2:0] desig_s1_r, desig_s2_r, desig_s3_r, desig_q_r;
   logic [WORD_W-1:0] recv_s1_r, recv_s2_r, recv_s3_r, recv_q_r;
   logic [WORD_W-1:0] proc_s1_r, proc_s2_r, proc_s3_r, proc_q_r;
   logic [BANKS*WORD_W-1:0] sense_s1_r, sense_s2_r, sense_s3_r, sense_q_r;

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         req_s1_r <= 3'h0;
         req_s2_r <= 3'h0;
         req_s3_r <= 3'h0;
         req_q_r <= 1'b0;
      end else begin
         req_s1_r <= {CHANNEL_IN, WRITE_IN, REQ_IN};
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
         if (req_s2_r[0] == req_s3_r[0]) req_q_r <= req_s3_r[0];
      end
   end

   // Presence is static strap wiring but still resynchronised for safety
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         fit_s1_r <= `CSB_BANKS_RST;
         fit_s2_r <= `CSB_BANKS_RST;
         fit_s3_r <= `CSB_BANKS_RST;
         fit_q_r <= `CSB_BANKS_RST;
      end else begin
         fit_s1_r <= BANK_FITTED_IN;
         fit_s2_r <= fit_s1_r;
         fit_s3_r <= fit_s2_r;
         if (fit_s2_r == fit_s3_r) fit_q_r <= fit_s3_r;
      end
   end

   // Bank designator crosses with the request, so both settle on the same edge
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         desig_s1_r <= '0;
         desig_s2_r <= '0;
         desig_s3_r <= '0;
         desig_q_r <= '0;
      end else begin
         desig_s1_r <= ADDR_IN[`CSB_BANK_MSB:`CSB_BANK_LSB];
         desig_s2_r <= desig_s1_r;
         desig_s3_r <= desig_s2_r;
         for (int i = 0; i < $bits(desig_q_r); i++) begin
            if (desig_s2_r[i] == desig_s3_r[i]) desig_q_r[i] <= desig_s3_r[i];
         end
      end
   end

   // Channel write data; it is held long before the write-load point
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         recv_s1_r <= '0;
         recv_s2_r <= '0;
         recv_s3_r <= '0;
         recv_q_r <= '0;
      end else begin
         recv_s1_r <= RECV_DATA_IN;
         recv_s2_r <= recv_s1_r;
         recv_s3_r <= recv_s2_r;
         for (int i = 0; i < WORD_W; i++) begin
            if (recv_s2_r[i] == recv_s3_r[i]) recv_q_r[i] <= recv_s3_r[i];
         end
      end
   end

   // Processor write data, same treatment as the channel side
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         proc_s1_r <= '0;
         proc_s2_r <= '0;
         proc_s3_r <= '0;
         proc_q_r <= '0;
      end else begin
         proc_s1_r <= PROC_DATA_IN;
         proc_s2_r <= proc_s1_r;
         proc_s3_r <= proc_s2_r;
         for (int i = 0; i < WORD_W; i++) begin
            if (proc_s2_r[i] == proc_s3_r[i]) proc_q_r[i] <= proc_s3_r[i];
         end
      end
   end

   // Sense lanes filtered bit by bit: idle lanes may toggle, which would stall a word match
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         sense_s1_r <= '0;
         sense_s2_r <= '0;
         sense_s3_r <= '0;
         sense_q_r <= '0;
      end else begin
         sense_s1_r <= SENSE_IN;
         sense_s2_r <= sense_s1_r;
         sense_s3_r <= sense_s2_r;
         for (int i = 0; i < BANKS*WORD_W; i++) begin
            if (sense_s2_r[i] == sense_s3_r[i]) sense_q_r[i] <= sense_s3_r[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage cycle sequencer

   csb_pkg::csb_state_type state_r;
   logic [8:0] cnt_r;
   logic is_chan_r;
   logic [2:0] bank_r;
   logic [2:0] bank_nxt;
   logic start;

   // Bank 0 is always present: bank zero is the last fallback
   assign bank_nxt = map_bank(desig_q_r,
                              {fit_q_r[7:1], 1'b1});
   // Rising edge of the filtered request; a held request is not retaken
   logic req_d_r;
   assign start = req_q_r & ~req_d_r & (state_r == csb_pkg::CSB_IDLE);

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_r <= csb_pkg::CSB_IDLE;
         cnt_r <= `CSB_CNT_RST;
         is_chan_r <= 1'b0;
         bank_r <= 3'h0;
         req_d_r <= 1'b0;
      end else begin
         req_d_r <= req_q_r;
         if (start) begin
            // Address and kind are latched at acceptance, like the address register
            state_r <= req_s3_r[1] ? csb_pkg::CSB_WRITE : csb_pkg::CSB_READ;
            is_chan_r <= req_s3_r[2];
            bank_r <= bank_nxt;
            cnt_r <= `CSB_CNT_RST;
         end else if (state_r != csb_pkg::CSB_IDLE) begin
            if (cnt_r == 9'(T_END - 1)) begin
               state_r <= csb_pkg::CSB_IDLE;
               cnt_r <= `CSB_CNT_RST;
            end else begin
               cnt_r <= cnt_r + 9'h001;
            end
         end
      end
   end

   logic active;
   logic at_read, at_wload, inh_phase;
   assign active = (state_r != csb_pkg::CSB_IDLE);
   assign at_read = active && (cnt_r == 9'(T_READ));
   assign at_wload = active && (cnt_r == 9'(T_WLOAD));
   assign inh_phase = active && (cnt_r >= 9'(T_INH));

   ////////////////////////////////////////////////////////////////////////////
   // Bank select and drive gating

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         BANK_SEL_N_OUT <= `CSB_BANKS_RST;
         READ_DRIVE_OUT <= '0;
         WRITE_DRIVE_OUT <= '0;
         BUSY_OUT <= 1'b0;
      end else begin
         BUSY_OUT <= active;
         for (int i = 0; i < BANKS; i++) begin
            // Active low: a one blocks selection
            BANK_SEL_N_OUT[i] <= !(active && bank_r == 3'(i));
            READ_DRIVE_OUT[i] <= active && bank_r == 3'(i) && cnt_r < 9'(T_WLOAD);
            WRITE_DRIVE_OUT[i] <= active && bank_r == 3'(i) && cnt_r >= 9'(T_WLOAD);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory data register

   logic [WORD_W-1:0] word_r;
   logic [WORD_W-1:0] sensed;

   // Only fitted banks feed the fan-in; bank 0 and 1 are always fitted
   always_comb begin
      sensed = '0;
      for (int b = 0; b < BANKS; b++) begin
         if ((b < `CSB_FIXED_BANKS || fit_q_r[b]) && bank_r == 3'(b))
            sensed = sensed | sense_q_r[b*WORD_W +: WORD_W];
      end
   end

   // A read keeps the word for write-back; a write replaces it
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         word_r <= `CSB_WORD_RST;
      end else if (at_read) begin
         word_r <= sensed;
      end else if (at_wload && state_r == csb_pkg::CSB_WRITE) begin
         word_r <= is_chan_r ? recv_q_r : proc_q_r;
      end
   end

   // Read word goes out to the processor side once captured
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         DATA_OUT <= `CSB_WORD_RST;
         DATA_VALID_OUT <= 1'b0;
      end else begin
         DATA_VALID_OUT <= at_read && state_r == csb_pkg::CSB_READ;
         if (at_read && state_r == csb_pkg::CSB_READ) DATA_OUT <= sensed;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Inhibit fan-out: zeros of the register, on every fitted bank

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         INHIBIT_OUT <= '0;
      end else begin
         for (int b = 0; b < BANKS; b++) begin
            // On a read, the same zeros restore the destroyed word
            INHIBIT_OUT[b*WORD_W +: WORD_W] <=
               (inh_phase && (b < `CSB_FIXED_BANKS || fit_q_r[b])) ? ~word_r : '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parity generators, low and high halves

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         PARITY_LO_N_OUT <= `CSB_PAR_RST;
         PARITY_HI_N_OUT <= `CSB_PAR_RST;
      end else begin
         PARITY_LO_N_OUT <= parity9(word_r[HALF-1:0]);
         PARITY_HI_N_OUT <= parity9(word_r[WORD_W-1:HALF]);
      end
   end
endmodule // csb_core_store_bank_data_path

// ===== csb_store_far_model.sv
`timescale 1ns/1ps
module csb_store_far_model (
   input wire logic clk_in,
   input wire logic [7:0] rdrv_in,
   input wire logic [7:0] wdrv_in,
   input wire logic [143:0] inh_in,
   output logic [143:0] sense_out
);
   logic [17:0] core_r [8];
   logic [7:0] rd_q_r = 8'h00;
   logic [17:0] junk_r = 18'h2AAAA;
   initial sense_out = 144'h0;
   // Cores start cleared so a first read gives a defined word
   initial begin
      for (int b = 0; b < 8; b++) core_r[b] = 18'h00000;
   end
   // Destructive read; idle sense lanes churn so a stray capture shows
   always @(posedge clk_in) begin
      junk_r <= {junk_r[16:0], ~junk_r[17]};
      rd_q_r <= rdrv_in;
      for (int b = 0; b < 8; b++) begin
         if (rdrv_in[b] && !rd_q_r[b]) begin
            sense_out[b*18+:18] <= core_r[b];
            core_r[b] <= 18'h00000;
         end else if (!rdrv_in[b]) sense_out[b*18+:18] <= junk_r ^ 18'(b);
         if (wdrv_in[b]) core_r[b] <= ~inh_in[b*18+:18];
      end
   end
endmodule // csb_store_far_model

// ===== csb_core_store_bank_data_path_sva.sv
`timescale 1ns/1ps
module csb_dp_sva #(parameter int WORD_W = 18, parameter int BANKS = 8) (
   input wire logic REF_CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic BUSY_OUT,
   input wire logic [BANKS-1:0] BANK_SEL_N_OUT,
   input wire logic [BANKS-1:0] READ_DRIVE_OUT,
   input wire logic [BANKS-1:0] WRITE_DRIVE_OUT,
   input wire logic [BANKS*WORD_W-1:0] INHIBIT_OUT,
   input wire logic DATA_VALID_OUT,
   input wire logic [WORD_W-1:0] DATA_OUT,
   input wire logic [2:0] PARITY_LO_N_OUT,
   input wire logic [2:0] PARITY_HI_N_OUT
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   ////////////////////////////////////////////////////////////////
   // Cycle start: idle then busy
   sequence s_start; !BUSY_OUT ##1 BUSY_OUT; endsequence
   property p_one_sel; BUSY_OUT |-> $onehot(~BANK_SEL_N_OUT); endproperty
   a_one_sel: assert property (p_one_sel) else $error("select not one-hot");
   property p_idle; !BUSY_OUT |-> &BANK_SEL_N_OUT && !(|READ_DRIVE_OUT); endproperty
   a_idle: assert property (p_idle) else $error("bank driven while idle");
   property p_rd_sel; (READ_DRIVE_OUT & BANK_SEL_N_OUT) == '0; endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("read drive off bank");
   property p_wr_sel; (WRITE_DRIVE_OUT & BANK_SEL_N_OUT) == '0; endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("write drive off bank");
   property p_first; s_start |-> READ_DRIVE_OUT != '0 && WRITE_DRIVE_OUT == '0; endproperty
   a_first: assert property (p_first) else $error("cycle not in read phase");
   property p_vpulse; DATA_VALID_OUT |=> !DATA_VALID_OUT; endproperty
   a_vpulse: assert property (p_vpulse) else $error("valid too long");
   // Read strobe lands a fixed 119 clocks after busy rises
   property p_vtime; DATA_VALID_OUT |-> $past(BUSY_OUT, 119) && !$past(BUSY_OUT, 120); endproperty
   a_vtime: assert property (p_vtime) else $error("read strobe mistimed");
   property p_wtime;
      $rose(|WRITE_DRIVE_OUT) |-> $past(BUSY_OUT, 150) && !$past(BUSY_OUT, 151);
   endproperty
   a_wtime: assert property (p_wtime) else $error("write load mistimed");
   property p_inh; INHIBIT_OUT != '0 |-> WRITE_DRIVE_OUT != '0; endproperty
   a_inh: assert property (p_inh) else $error("inhibit outside write");
   // Parity tracks the captured word one clock after the read strobe
   property p_par;
      DATA_VALID_OUT |=> ((PARITY_LO_N_OUT == 3'h7) == ~^DATA_OUT[WORD_W/2-1:0])
         && ((PARITY_HI_N_OUT == 3'h7) == ~^DATA_OUT[WORD_W-1:WORD_W/2]);
   endproperty
   a_par: assert property (p_par) else $error("parity wrong for read word");
   property p_par_one;
      $countones(~PARITY_LO_N_OUT) <= 1 && $countones(~PARITY_HI_N_OUT) <= 1;
   endproperty
   a_par_one: assert property (p_par_one) else $error("parity has two outputs low");
endmodule // csb_dp_sva
bind csb_core_store_bank_data_path csb_dp_sva #(.WORD_W(WORD_W), .BANKS(BANKS)) sva_u (
   .REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN), .BUSY_OUT(BUSY_OUT),
   .BANK_SEL_N_OUT(BANK_SEL_N_OUT), .READ_DRIVE_OUT(READ_DRIVE_OUT),
   .WRITE_DRIVE_OUT(WRITE_DRIVE_OUT), .INHIBIT_OUT(INHIBIT_OUT),
   .DATA_VALID_OUT(DATA_VALID_OUT), .DATA_OUT(DATA_OUT),
   .PARITY_LO_N_OUT(PARITY_LO_N_OUT), .PARITY_HI_N_OUT(PARITY_HI_N_OUT));

// ===== csb_core_store_bank_data_path_tb.sv
`timescale 1ns/1ps
module csb_core_store_bank_data_path_tb;
   logic clk = 0, arst_n = 0, req = 0, wr = 0, ch = 0, busy, dval;
   logic [14:0] addr = 15'h0000;
   logic [7:0] fit = 8'hFF, seln, rdrv, wdrv;
   logic [17:0] rdat = 18'h00000, pdat = 18'h00000, dout;
   logic [143:0] sense, inh;
   logic [2:0] plo, phi;
   int mismatches = 0, comparisons = 0;
   string map [8] = '{"00000000", "01010101", "01220122", "01230123",
      "01234444", "01234545", "01234566", "01234567"};
   // Free-running 250 MHz clock
   always #2 clk = ~clk;
   csb_core_store_bank_data_path dut_u (.REF_CLK_IN(clk), .ARST_N_IN(arst_n),
      .REQ_IN(req), .WRITE_IN(wr), .CHANNEL_IN(ch), .ADDR_IN(addr), .BANK_FITTED_IN(fit),
      .SENSE_IN(sense), .RECV_DATA_IN(rdat), .PROC_DATA_IN(pdat), .BUSY_OUT(busy),
      .BANK_SEL_N_OUT(seln), .READ_DRIVE_OUT(rdrv), .WRITE_DRIVE_OUT(wdrv),
      .INHIBIT_OUT(inh), .DATA_OUT(dout), .DATA_VALID_OUT(dval),
      .PARITY_LO_N_OUT(plo), .PARITY_HI_N_OUT(phi));
   csb_store_far_model far_u (.clk_in(clk), .rdrv_in(rdrv), .wdrv_in(wdrv),
      .inh_in(inh), .sense_out(sense));
   ////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("%0d compares, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task cmp(input logic [17:0] got, input logic [17:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One storage cycle; the unused source carries the inverse to catch a mix-up
   task automatic acc(input logic w, input logic c, input logic [2:0] d,
      input logic [17:0] v, output logic [17:0] q, output logic [7:0] s);
      int n;
      @(negedge clk);
      wr = w; ch = c; addr = {d, 12'h5A3}; pdat = c ? ~v : v; rdat = c ? v : ~v; req = 1;
      n = 0;
      while (busy !== 1'b1 && n < 20) begin @(negedge clk); n++; end
      s = seln; req = 0; q = 'x; n = 0;
      while (busy === 1'b1 && n < 300) begin
         if (dval === 1'b1) q = dout;
         @(negedge clk); n++;
      end
      if (n == 0 || n >= 300) begin
         mismatches++;
         $display("[ERR] %0t cycle timeout", $time);
         end_of_test;
      end
      repeat (4) @(negedge clk);
   endtask
   task automatic rd(input logic [2:0] d, input logic [17:0] e);
      logic [17:0] q;
      logic [7:0] s;
      acc(0, d[0], d, 18'h00000, q, s);
      cmp(q, e, "read word");
      cmp({16'h0000, plo === 3'h7, phi === 3'h7}, {16'h0000, ~^e[8:0], ~^e[17:9]}, "parity");
   endtask
   task automatic t_map;
      logic [17:0] q;
      logic [7:0] s;
      for (int nb = 1; nb <= 8; nb++) begin
         fit = 8'hFF >> (8 - nb);
         repeat (8) @(negedge clk);
         for (int d = 0; d < 8; d++) begin
            acc(0, 0, d[2:0], 18'h00000, q, s);
            cmp({10'h000, s}, {10'h000, ~(8'h01 << (map[nb-1][d] - "0"))}, "bank");
         end
      end
      $display("bank map test done");
   endtask
   task automatic t_data;
      logic [17:0] q;
      logic [7:0] s;
      fit = 8'hFF;
      repeat (8) @(negedge clk);
      acc(1, 0, 3'h3, 18'h2B5C3, q, s);
      acc(1, 1, 3'h5, 18'h14A3C, q, s);
      rd(3'h3, 18'h2B5C3);
      rd(3'h3, 18'h2B5C3);
      rd(3'h5, 18'h14A3C);
      $display("data path test done");
   endtask
   // Banks 5 to 7 absent: their churning sense lanes must never reach the word
   task automatic t_absent;
      logic [17:0] q;
      logic [7:0] s;
      fit = 8'h1F;
      repeat (8) @(negedge clk);
      acc(1, 1, 3'h7, 18'h0F0F5, q, s);
      rd(3'h6, 18'h0F0F5);
      rd(3'h4, 18'h0F0F5);
      $display("absent bank test done");
   endtask
   // Reset for 12 clocks, then the scenarios
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      arst_n = 1;
      repeat (8) @(negedge clk);
      t_map;
      t_data;
      t_absent;
      end_of_test;
   end
endmodule // csb_core_store_bank_data_path_tb
